/* rtl/lies_pkg.sv */
// Constants for the local interrupt error and spurious block.
// Assumes byte addresses within a 4 Kbyte register window.
package lies_pkg;
	localparam int ADDR_W = 12;
	localparam int NSRC = 6;
	localparam int NEXT = 4;
	// Register byte offsets
	localparam logic [11:0] SPUR_OFF = 12'h0F0;
	localparam logic [11:0] ESR_OFF = 12'h280;
	localparam logic [11:0] EXTF_OFF = 12'h400;
	localparam logic [11:0] IRQ_STAT_OFF = 12'h600;
	localparam logic [11:0] IRQ_EN_OFF = 12'h604;
	// Vector entries: thermal, error, extended 0..3
	localparam logic [NSRC-1:0][11:0] LVT_OFF = {12'h530, 12'h520,
		12'h510, 12'h500, 12'h370, 12'h330};
	localparam int SRC_THERM = 0;
	localparam int SRC_ERR = 1;
	localparam int SRC_EXT0 = 2;
	// Entry fields
	localparam int VEC_LSB = 0;
	localparam int MT_LSB = 8;
	localparam int DS_BIT = 12;
	localparam int MASK_BIT = 16;
	localparam logic [31:0] LVT_WR_MASK = 32'h0001_07FF;
	localparam logic [31:0] LVT_RST = 32'h0001_0000;
	localparam logic [7:0] MIN_LEGAL_VEC = 8'h10;
	// Spurious register fields
	localparam int SWEN_BIT = 8;
	localparam int FCD_BIT = 9;
	localparam logic [31:0] SPUR_WR_MASK = 32'h0000_03FF;
	localparam logic [31:0] SPUR_RST = 32'h0000_00FF;
	// Error status bits
	localparam int ESR_SENT_ACC = 2;
	localparam int ESR_RECV_ACC = 3;
	localparam int ESR_SENT_VEC = 5;
	localparam int ESR_RECV_VEC = 6;
	localparam int ESR_BAD_REG = 7;
	// Extended feature count field
	localparam int EXTF_CNT_LSB = 16;
	localparam logic [7:0] EXT_COUNT = 8'h04;
	localparam logic THERMAL_SUPPORTED = 1'b1;
	// Interrupt status bits
	localparam int IRQ_W = 5;
	localparam int IRQ_THERM = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_SPUR = 2;
	localparam int IRQ_EXT = 3;
	localparam int IRQ_REFUSE = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MT_FIXED = 3'h0, MT_LOWEST = 3'h1, MT_SMI = 3'h2, MT_RREAD = 3'h3,
		MT_NMI = 3'h4, MT_INIT = 3'h5, MT_STARTUP = 3'h6, MT_EXTERNAL_INTERRUPT = 3'h7
	} lies_msg_t;
endpackage : lies_pkg

/* rtl/lies_top.sv */
// Vector entries, error status and spurious control of a local
// interrupt controller, registers over AXI4-Lite.
// Assumes event inputs are pulses from logic on aclk.
// Overview of operation
// - Thermal event requests via unmasked thermal entry
// - Feature register reports extended entry count
// - Four extended entries at 500h to 530h
// - Detected errors request via unmasked error entry
// - Status write loads accumulated errors, clears them
// - Bit 2: sent message accepted by nobody
// - Bit 3: received message accepted by nobody
// - Bit 5: sending illegal vector attempted
// - Bit 6: received illegal vector
// - Bit 7: unimplemented register in window accessed
// - Priority raised during acknowledge gives spurious vector
// - Spurious leaves in-service untouched, no end_of_interrupt
// - Disabled unit refuses fixed, lowest, external only, and accepts them from a pin
// - Disabled unit forces all entry masks set
// - Focus check skipped when disable bit set
// - Set mask blocks entry, clear mask allows
// - Fixed entry vector below 16 is error
`timescale 1ns/1ps
module lies_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic thermal_event,
	input wire logic [3:0] ext_event,
	input wire logic sent_accept_fail,
	input wire logic recv_accept_fail,
	input wire logic sent_bad_vector,
	input wire logic recv_bad_vector,
	output logic dlv_valid,
	output logic [7:0] dlv_vector,
	output logic [2:0] dlv_type,
	input wire logic dlv_ready,
	input wire logic ack_start,
	input wire logic [3:0] ack_level,
	input wire logic [3:0] task_priority,
	input wire logic [7:0] ack_vector_in,
	output logic ack_done,
	output logic ack_spurious,
	output logic [7:0] ack_vector,
	output logic isr_set,
	input wire logic msg_valid,
	input wire logic [2:0] msg_type,
	input wire logic msg_from_pin,
	output logic msg_accept,
	input wire logic lp_valid,
	input wire logic isr_hit,
	input wire logic irr_hit,
	output logic focus_claim,
	output logic software_unit_enable,
	output logic focus_check_disable,
	output logic irq
);
	localparam int N = lies_pkg::NSRC;

	logic bvalid_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [31:0] spur_ff;
	logic [31:0] lvt_ff [N];
	logic [N-1:0] pend_ff;
	logic [7:0] accum_ff, esr_ff;
	logic [lies_pkg::IRQ_W-1:0] irq_stat_ff, irq_en_ff;
	logic dlv_valid_ff;
	logic [7:0] dlv_vector_ff;
	logic [2:0] dlv_type_ff;
	logic ack_done_ff, ack_spur_ff, isr_set_ff;
	logic [7:0] ack_vector_ff;

	logic wr_fire, rd_fire, swen, fcd;
	logic [11:0] wr_addr, rd_addr;
	logic wr_hit, rd_hit, wr_bad, rd_bad;
	logic [31:0] wr_data, rd_mux;
	logic esr_wr;
	logic [7:0] err_set, accum_base, nxt_accum;
	logic err_new;
	logic [N-1:0] trig, accept, illegal, lvt_sel_wr, lvt_sel_rd, grant;
	logic take;
	logic spur_now;
	logic [lies_pkg::IRQ_W-1:0] irq_set;

	// AXI4-Lite handshakes: address and data taken together
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign rd_fire = s_axi_arvalid && !rvalid_ff;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = rd_fire;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;
	assign wr_addr = {s_axi_awaddr[11:2], 2'h0};
	assign rd_addr = {s_axi_araddr[11:2], 2'h0};

	assign swen = spur_ff[lies_pkg::SWEN_BIT];
	assign fcd = spur_ff[lies_pkg::FCD_BIT];
	assign software_unit_enable = swen;
	assign focus_check_disable = fcd;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic fixed_reg(input logic [11:0] a);
		return a == lies_pkg::SPUR_OFF || a == lies_pkg::ESR_OFF ||
			a == lies_pkg::EXTF_OFF || a == lies_pkg::IRQ_STAT_OFF ||
			a == lies_pkg::IRQ_EN_OFF;
	endfunction : fixed_reg

	assign wr_hit = fixed_reg(wr_addr) || |lvt_sel_wr;
	assign rd_hit = fixed_reg(rd_addr) || |lvt_sel_rd;
	assign wr_bad = wr_fire && !wr_hit;
	assign rd_bad = rd_fire && !rd_hit;
	assign esr_wr = wr_fire && wr_addr == lies_pkg::ESR_OFF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= lies_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? lies_pkg::RESP_OKAY : lies_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= lies_pkg::RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_hit ? lies_pkg::RESP_OKAY : lies_pkg::RESP_SLVERR;
			rdata_ff <= rd_mux;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (rd_addr == lies_pkg::SPUR_OFF) begin
			rd_mux = spur_ff;
		end else if (rd_addr == lies_pkg::ESR_OFF) begin
			rd_mux = {24'h000000, esr_ff};
		end else if (rd_addr == lies_pkg::EXTF_OFF) begin
			rd_mux[lies_pkg::EXTF_CNT_LSB +: 8] = lies_pkg::EXT_COUNT;
		end else if (rd_addr == lies_pkg::IRQ_STAT_OFF) begin
			rd_mux[lies_pkg::IRQ_W-1:0] = irq_stat_ff;
		end else if (rd_addr == lies_pkg::IRQ_EN_OFF) begin
			rd_mux[lies_pkg::IRQ_W-1:0] = irq_en_ff;
		end
		for (int i = 0; i < N; i++) begin
			if (lvt_sel_rd[i]) begin
				rd_mux = lvt_ff[i];
				rd_mux[lies_pkg::DS_BIT] = pend_ff[i];
			end
		end
	end

	// Spurious vector, unit enable and focus-check control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spur_ff <= lies_pkg::SPUR_RST;
		end else if (wr_fire && wr_addr == lies_pkg::SPUR_OFF) begin
			spur_ff <= merge(spur_ff, s_axi_wdata, s_axi_wstrb) &
				lies_pkg::SPUR_WR_MASK;
		end
	end

	// Error accumulation; set wins over the clearing write
	always_comb begin
		err_set = 8'h00;
		err_set[lies_pkg::ESR_SENT_ACC] = sent_accept_fail;
		err_set[lies_pkg::ESR_RECV_ACC] = recv_accept_fail;
		err_set[lies_pkg::ESR_SENT_VEC] = sent_bad_vector | |illegal;
		err_set[lies_pkg::ESR_RECV_VEC] = recv_bad_vector;
		err_set[lies_pkg::ESR_BAD_REG] = wr_bad | rd_bad;
	end
	assign accum_base = esr_wr ? 8'h00 : accum_ff;
	assign nxt_accum = accum_base | err_set;
	assign err_new = |(err_set & ~accum_base);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			accum_ff <= 8'h00;
			esr_ff <= 8'h00;
		end else begin
			accum_ff <= nxt_accum;
			if (esr_wr) begin
				esr_ff <= accum_ff;
			end
		end
	end

	assign trig[lies_pkg::SRC_THERM] = thermal_event &
		lies_pkg::THERMAL_SUPPORTED;
	assign trig[lies_pkg::SRC_ERR] = err_new;
	assign trig[lies_pkg::SRC_EXT0 +: lies_pkg::NEXT] = ext_event;

	// Per-entry storage, mask gating and pending state
	for (genvar g = 0; g < N; g++) begin : g_lvt
		assign lvt_sel_wr[g] = wr_addr == lies_pkg::LVT_OFF[g];
		assign lvt_sel_rd[g] = rd_addr == lies_pkg::LVT_OFF[g];
		assign accept[g] = trig[g] && !lvt_ff[g][lies_pkg::MASK_BIT];
		assign illegal[g] = accept[g] &&
			lvt_ff[g][lies_pkg::MT_LSB +: 3] == lies_pkg::MT_FIXED &&
			lvt_ff[g][lies_pkg::VEC_LSB +: 8] < lies_pkg::MIN_LEGAL_VEC;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				lvt_ff[g] <= lies_pkg::LVT_RST;
			end else begin
				if (wr_fire && lvt_sel_wr[g]) begin
					lvt_ff[g] <= merge(lvt_ff[g], s_axi_wdata, s_axi_wstrb) &
						lies_pkg::LVT_WR_MASK;
				end
				if (!swen) begin
					lvt_ff[g][lies_pkg::MASK_BIT] <= 1'b1;
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pend_ff[g] <= 1'b0;
			end else begin
				pend_ff[g] <= (accept[g] && !illegal[g]) ||
					(pend_ff[g] && !grant[g]);
			end
		end
	end

	// Fixed-priority pick, lowest entry index first
	assign take = !dlv_valid_ff || dlv_ready;
	always_comb begin
		grant = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (take && pend_ff[i]) begin
				grant = '0;
				grant[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dlv_valid_ff <= 1'b0;
			dlv_vector_ff <= 8'h00;
			dlv_type_ff <= 3'h0;
		end else if (take) begin
			dlv_valid_ff <= |grant;
			for (int i = 0; i < N; i++) begin
				if (grant[i]) begin
					dlv_vector_ff <= lvt_ff[i][lies_pkg::VEC_LSB +: 8];
					dlv_type_ff <= lvt_ff[i][lies_pkg::MT_LSB +: 3];
				end
			end
		end
	end
	assign dlv_valid = dlv_valid_ff;
	assign dlv_vector = dlv_vector_ff;
	assign dlv_type = dlv_type_ff;

	// Acknowledge: spurious when priority caught up with the level
	assign spur_now = ack_start && task_priority >= ack_level;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_done_ff <= 1'b0;
			ack_spur_ff <= 1'b0;
			isr_set_ff <= 1'b0;
			ack_vector_ff <= 8'h00;
		end else begin
			ack_done_ff <= ack_start;
			ack_spur_ff <= spur_now;
			isr_set_ff <= ack_start && !spur_now;
			if (ack_start) begin
				ack_vector_ff <= spur_now ? spur_ff[7:0] : ack_vector_in;
			end
		end
	end
	assign ack_done = ack_done_ff;
	assign ack_spurious = ack_spur_ff;
	assign ack_vector = ack_vector_ff;
	assign isr_set = isr_set_ff;

	// Message acceptance while the unit is disabled
	always_comb begin
		msg_accept = 1'b0;
		if (msg_valid) begin
			unique case (lies_pkg::lies_msg_t'(msg_type))
				lies_pkg::MT_FIXED, lies_pkg::MT_LOWEST, lies_pkg::MT_EXTERNAL_INTERRUPT:
					msg_accept = swen || msg_from_pin;
				lies_pkg::MT_SMI, lies_pkg::MT_RREAD, lies_pkg::MT_NMI,
				lies_pkg::MT_INIT, lies_pkg::MT_STARTUP:
					msg_accept = 1'b1;
			endcase
		end
	end

	assign focus_claim = lp_valid && !fcd && (isr_hit || irr_hit);

	// Interrupt status: set wins over write-one-to-clear
	always_comb begin
		irq_set = '0;
		irq_set[lies_pkg::IRQ_THERM] = accept[lies_pkg::SRC_THERM];
		irq_set[lies_pkg::IRQ_ERR] = err_new;
		irq_set[lies_pkg::IRQ_SPUR] = spur_now;
		irq_set[lies_pkg::IRQ_EXT] = |accept[lies_pkg::SRC_EXT0 +: 4];
		irq_set[lies_pkg::IRQ_REFUSE] = msg_valid && !msg_accept;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= '0;
		end else if (wr_fire && wr_addr == lies_pkg::IRQ_STAT_OFF &&
			s_axi_wstrb[0]) begin
			irq_stat_ff <= (irq_stat_ff & ~s_axi_wdata[lies_pkg::IRQ_W-1:0]) |
				irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_ff <= '0;
		end else if (wr_fire && wr_addr == lies_pkg::IRQ_EN_OFF &&
			s_axi_wstrb[0]) begin
			irq_en_ff <= s_axi_wdata[lies_pkg::IRQ_W-1:0];
		end
	end
	assign irq = |(irq_stat_ff & irq_en_ff);

	// Checks
	therm_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		thermal_event && lvt_ff[0][16] |=> !pend_ff[0] || $past(pend_ff[0]))
		else $error("masked thermal event became pending");
	err_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
		err_new && !lvt_ff[1][16] && !illegal[1] |=> pend_ff[1])
		else $error("error entry not requested");
	ext_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire && rd_addr == 12'h400 |=> s_axi_rdata[23:16] == 8'h04)
		else $error("extended count wrong");
	esr_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		esr_wr |=> esr_ff == $past(accum_ff) && accum_ff == $past(err_set))
		else $error("status write did not load and clear");
	sent_acc_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sent_accept_fail |=> accum_ff[2]) else $error("bit 2 not set");
	recv_acc_a: assert property (@(posedge aclk) disable iff (!aresetn)
		recv_accept_fail |=> accum_ff[3]) else $error("bit 3 not set");
	bad_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sent_bad_vector || recv_bad_vector |=> accum_ff[5] || accum_ff[6])
		else $error("vector error bit not set");
	bad_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire && !rd_hit |=> accum_ff[7] && s_axi_rresp == 2'h2)
		else $error("unmapped read not flagged");
	spur_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		spur_now |=> ack_spurious && !isr_set && ack_vector == $past(spur_ff[7:0]))
		else $error("spurious delivery wrong");
	mask_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!swen [*2] |-> lvt_ff[2][16] && lvt_ff[0][16])
		else $error("mask clear while disabled");
	refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		msg_valid && !swen && !msg_from_pin && msg_type == 3'h0 |-> !msg_accept)
		else $error("fixed message taken while disabled");
	focus_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fcd |-> !focus_claim) else $error("focus check not skipped");
	illegal_a: assert property (@(posedge aclk) disable iff (!aresetn)
		|illegal |=> accum_ff[5]) else $error("illegal entry vector missed");
	err_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
		err_new |-> !accum_ff[7] || !err_set[7] || esr_wr ||
		err_set[6:0] != 7'h00) else $error("error re-requested");
	spur_c: cover property (@(posedge aclk) disable iff (!aresetn) spur_now);
	dlv_c: cover property (@(posedge aclk) disable iff (!aresetn)
		dlv_valid && dlv_ready);
	esr_c: cover property (@(posedge aclk) disable iff (!aresetn)
		esr_wr && |accum_ff);
	irq_c: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule : lies_top

/* tb/lies_core_model.sv */
// Core handler model that takes deliveries from the block.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ps
module lies_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic dlv_valid,
	input wire logic [7:0] dlv_vector,
	input wire logic [2:0] dlv_type,
	output logic dlv_ready,
	output int count,
	output logic [7:0] last_vec,
	output logic [2:0] last_type
);
	logic [1:0] gap_ff;
	// Slow mode takes a delivery only one cycle in four
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_ff <= 2'h0;
			dlv_ready <= 1'h0;
			count <= 0;
		end else begin
			gap_ff <= gap_ff + 2'h1;
			dlv_ready <= !slow || gap_ff == 2'h3;
			if (dlv_valid && dlv_ready) begin
				count <= count + 1;
				last_vec <= dlv_vector;
				last_type <= dlv_type;
			end
		end
	end
endmodule : lies_core_model

/* tb/local_int_error_and_spurious_bench.sv */
// Self-checking bench for the vector entry and error status block.
// Assumes the core handler model and the design package.
`timescale 1ns/1ps
module local_int_error_and_spurious_bench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic awready, wready, bvalid, arready, rvalid, slow;
	logic [1:0] bresp, rresp, r;
	logic [3:0] ext_event, err_in, ack_level, task_priority;
	logic thermal_event, dlv_valid, dlv_ready, ack_start, ack_done;
	logic ack_spurious, isr_set, msg_valid, msg_from_pin, msg_accept;
	logic lp_valid, isr_hit, irr_hit, focus_claim, irq, swen, fcd;
	logic [7:0] dlv_vector, ack_vector_in, ack_vector, last_vec, sv, tv;
	logic [2:0] dlv_type, msg_type, last_type;
	int count, miscompares, total_checks, seed, c0, bitpos[4];

	lies_top u_lies_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .thermal_event(thermal_event),
		.ext_event(ext_event), .sent_accept_fail(err_in[0]),
		.recv_accept_fail(err_in[1]), .sent_bad_vector(err_in[2]),
		.recv_bad_vector(err_in[3]), .dlv_valid(dlv_valid),
		.dlv_vector(dlv_vector), .dlv_type(dlv_type), .dlv_ready(dlv_ready),
		.ack_start(ack_start), .ack_level(ack_level),
		.task_priority(task_priority), .ack_vector_in(ack_vector_in),
		.ack_done(ack_done), .ack_spurious(ack_spurious),
		.ack_vector(ack_vector), .isr_set(isr_set), .msg_valid(msg_valid),
		.msg_type(msg_type), .msg_from_pin(msg_from_pin),
		.msg_accept(msg_accept), .lp_valid(lp_valid), .isr_hit(isr_hit),
		.irr_hit(irr_hit), .focus_claim(focus_claim),
		.software_unit_enable(swen), .focus_check_disable(fcd), .irq(irq));

	lies_core_model u_lies_core_model (.aclk(aclk), .aresetn(aresetn),
		.slow(slow), .dlv_valid(dlv_valid), .dlv_vector(dlv_vector),
		.dlv_type(dlv_type), .dlv_ready(dlv_ready), .count(count),
		.last_vec(last_vec), .last_type(last_type));

	always #20 aclk = ~aclk;

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'h1) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk

	task automatic tmo(input string m);
		chk(1'h0, m);
		results();
	endtask : tmo

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic pa, pw, ta, tw;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		pa = 1'h1;
		pw = 1'h1;
		for (n = 0; n < 40 && (pa || pw); n++) begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		if (pa || pw) tmo("write not taken");
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			if (bvalid === 1'h1) break;
		end
		if (n == 40) tmo("no write answer");
		r = bresp;
		@(posedge aclk);
		bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		logic t;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
			if (t) break;
		end
		arvalid <= 1'h0;
		if (n == 40) tmo("read not taken");
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			if (rvalid === 1'h1) break;
		end
		if (n == 40) tmo("no read answer");
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'h0;
	endtask : rd

	// Event index: 0 thermal, 1..4 extended, 5..8 error inputs
	task automatic pulse(input int k);
		c0 = count;
		@(posedge aclk);
		if (k == 0) thermal_event <= 1'h1;
		else if (k < 5) ext_event[k-1] <= 1'h1;
		else err_in[k-5] <= 1'h1;
		@(posedge aclk);
		thermal_event <= 1'h0;
		ext_event <= 4'h0;
		err_in <= 4'h0;
	endtask : pulse

	task automatic got(input logic [7:0] v);
		int n;
		for (n = 0; n < 40 && count == c0; n++) @(posedge aclk);
		if (n == 40) tmo("no delivery");
		chk(count == c0 + 1 && last_vec === v && last_type === 3'h0, "dlv");
	endtask : got

	task automatic none;
		repeat (12) @(posedge aclk);
		chk(count == c0, "unexpected delivery");
	endtask : none

	task automatic entry(input int i, input logic m, input logic [7:0] v);
		wr(lies_pkg::LVT_OFF[i], {15'h0, m, 8'h0, v});
	endtask : entry

	task automatic msgs(input logic en);
		for (int k = 0; k < 16; k++) begin
			@(posedge aclk);
			msg_valid <= 1'h1;
			msg_type <= k[2:0];
			msg_from_pin <= k[3];
			@(negedge aclk);
			chk(msg_accept === (en || k[3] || !(k[2:0] inside {3'h0, 3'h1,
				3'h7})), "message accept");
		end
		@(posedge aclk);
		msg_valid <= 1'h0;
	endtask : msgs

	initial begin
		seed = 21;
		bitpos = '{2, 3, 5, 6};
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata, slow, ext_event, err_in} = 65'h0;
		{ack_level, task_priority, ack_vector_in, ack_start} = 17'h0;
		{thermal_event, msg_valid, msg_type, msg_from_pin} = 6'h0;
		{lp_valid, isr_hit, irr_hit, miscompares, total_checks} = 67'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rd(lies_pkg::SPUR_OFF);
		chk(d === 32'h0000_00FF && swen === 1'h0, "spurious reset");
		for (int i = 0; i < 6; i++) begin
			rd(lies_pkg::LVT_OFF[i]);
			chk(d === 32'h0001_0000, "entry reset");
		end
		rd(lies_pkg::EXTF_OFF);
		chk(d[23:16] === 8'h04, "extended count");
		rd(12'h004);
		chk(r === lies_pkg::RESP_SLVERR, "unmapped read");
		wr(12'hFFC, 32'h0);
		chk(r === lies_pkg::RESP_SLVERR, "unmapped write");
		wr(lies_pkg::ESR_OFF, 32'h0);
		rd(lies_pkg::ESR_OFF);
		chk(d === 32'h0000_0080, "bad register bit");
		wr(lies_pkg::ESR_OFF, 32'h0);
		rd(lies_pkg::ESR_OFF);
		chk(d === 32'h0, "error state cleared");
		entry(0, 1'h0, 8'h40);
		rd(lies_pkg::LVT_OFF[0]);
		chk(d[16] === 1'h1, "mask forced");
		pulse(0);
		none();
		msgs(1'h0);
		$display("test reset and disabled unit done");
		sv = 8'($random(seed));
		for (int f = 0; f < 2; f++) begin
			wr(lies_pkg::SPUR_OFF, {22'h0, f[0], 1'h1, sv});
			chk(swen === 1'h1 && fcd === f[0], "control bits");
			for (int j = 0; j < 8; j++) begin
				@(posedge aclk);
				{lp_valid, isr_hit, irr_hit} <= j[2:0];
				@(negedge aclk);
				chk(focus_claim === (j[2] && !f[0] && j[1:0] != 2'h0),
					"focus");
			end
		end
		msgs(1'h1);
		$display("test enable and focus done");
		tv = 8'h40 | (8'($random(seed)) & 8'h3F);
		entry(0, 1'h1, tv);
		pulse(0);
		none();
		entry(0, 1'h0, tv);
		pulse(0);
		got(tv);
		rd(lies_pkg::IRQ_STAT_OFF);
		chk(d[0] === 1'h1 && irq === 1'h0, "irq held off");
		wr(lies_pkg::IRQ_EN_OFF, 32'h1);
		@(negedge aclk);
		chk(irq === 1'h1, "irq raised");
		wr(lies_pkg::IRQ_STAT_OFF, 32'h1);
		@(negedge aclk);
		chk(irq === 1'h0, "irq cleared");
		wr(lies_pkg::IRQ_EN_OFF, 32'h0);
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			entry(i + 2, 1'h0, 8'h50 + 8'(i));
			pulse(i + 1);
			got(8'h50 + 8'(i));
		end
		$display("test thermal and extended done");
		entry(1, 1'h0, 8'h60);
		for (int i = 0; i < 4; i++) begin
			pulse(5 + i);
			got(8'h60);
			pulse(5 + i);
			none();
			wr(lies_pkg::ESR_OFF, 32'h0);
			rd(lies_pkg::ESR_OFF);
			chk(d === 32'h1 << bitpos[i], "error bit");
		end
		entry(0, 1'h0, 8'($random(seed)) & 8'h0F);
		pulse(0);
		got(8'h60);
		wr(lies_pkg::ESR_OFF, 32'h0);
		rd(lies_pkg::ESR_OFF);
		chk(d === 32'h0000_0020, "low vector");
		$display("test errors done");
		for (int i = 0; i < 8; i++) begin
			@(posedge aclk);
			ack_level <= 4'($random(seed));
			ack_vector_in <= 8'($random(seed));
			task_priority <= (i == 0) ? 4'h0 : (i == 1) ? 4'hF :
				4'($random(seed));
			ack_start <= 1'h1;
			@(posedge aclk);
			ack_start <= 1'h0;
			@(negedge aclk);
			if (task_priority >= ack_level)
				chk(ack_spurious === 1'h1 && isr_set === 1'h0 &&
					ack_done === 1'h1 && ack_vector === sv,
					"spurious");
			else
				chk(ack_spurious === 1'h0 && isr_set === 1'h1 &&
					ack_done === 1'h1 && ack_vector === ack_vector_in,
					"normal ack");
		end
		wr(lies_pkg::SPUR_OFF, 32'h0);
		rd(lies_pkg::LVT_OFF[1]);
		chk(d[16] === 1'h1, "mask forced again");
		msgs(1'h0);
		$display("test acknowledge and disable done");
		results();
	end
endmodule : local_int_error_and_spurious_bench
